// *** src/can_ctl_pkg.sv ***
package can_ctl_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFF_FILTER_CTRL = 8'h00;
  localparam logic [7:0] OFF_FIFO_CTRL   = 8'h04;
  localparam logic [7:0] OFF_MAIN_CTRL   = 8'h08;
  localparam logic [7:0] OFF_IRQ_STATUS  = 8'h0C;
  localparam logic [7:0] OFF_IRQ_MASK    = 8'h10;
  localparam logic [7:0] OFF_MATCH_STAT  = 8'h14;

  // ----------------------------------------------------------------------
  // Filter control word layout
  // ----------------------------------------------------------------------
  localparam int FLT_HI_BASE     = 24;
  localparam int FLT_LO_BASE     = 16;
  localparam int FLT_EN_POS      = 7;
  localparam int FLT_MSEL_LSB    = 5;
  localparam int FLT_FSEL_LSB    = 0;

  // ----------------------------------------------------------------------
  // FIFO control word layout
  // ----------------------------------------------------------------------
  localparam int FIFO_ABORT_POS  = 6;
  localparam int FIFO_LARB_POS   = 5;
  localparam int FIFO_BERR_POS   = 4;
  localparam int FIFO_REQ_POS    = 3;
  localparam int FIFO_RTR_POS    = 2;
  localparam int FIFO_PRI_LSB    = 0;
  localparam int FIFO_DIR_POS    = 7;

  // ----------------------------------------------------------------------
  // Main control layout and mode codes
  // ----------------------------------------------------------------------
  localparam int          MODE_LSB  = 21;
  localparam logic [2:0]  MODE_CONFIG = 3'h4;
  localparam logic [2:0]  MODE_RESET  = 3'h4;

  // ----------------------------------------------------------------------
  // Interrupt status layout
  // ----------------------------------------------------------------------
  localparam int IRQ_DONE_POS    = 0;
  localparam int IRQ_ABORT_POS   = 1;
  localparam int IRQ_LARB_POS    = 2;
  localparam int IRQ_BERR_POS    = 3;
  localparam int IRQ_MATCH_POS   = 4;

  localparam logic [31:0] RESET_WORD = 32'h0000_0000;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_BUSY = 2'b01,
    TX_ABRT = 2'b11
  } tx_state_t;

endpackage

// *** src/can_filter_fifo_tx_control.sv ***
`timescale 1ns/1ps
module can_filter_fifo_tx_control (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_b_in,
  // Wishbone slave
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  input  wire logic        wb_we_in,
  input  wire logic [7:0]  wb_adr_in,
  input  wire logic [3:0]  wb_sel_in,
  input  wire logic [31:0] wb_dat_in,
  output logic      [31:0] wb_dat_out,
  output logic             wb_ack_out,
  // Receive side of the protocol engine
  input  wire logic        rx_valid_in,
  input  wire logic [1:0]  rx_filter_in,
  input  wire logic        rx_remote_in,
  input  wire logic        rx_id_hit_in,
  // Transmit side of the protocol engine
  input  wire logic        tx_done_in,
  input  wire logic        tx_aborted_in,
  input  wire logic        tx_lost_arb_in,
  input  wire logic        tx_bus_err_in,
  input  wire logic        tx_queue_empty_in,
  input  wire logic        fifo_reset_in,
  // Outputs to the engine and system
  output logic             tx_request_out,
  output logic             tx_abort_out,
  output logic [1:0]       tx_priority_out,
  output logic [1:0]       mask_sel_out,
  output logic [4:0]       store_fifo_out,
  output logic             store_valid_out,
  output logic             irq_out
);
  import can_ctl_pkg::*;

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [31:0] flt;
    logic [7:0]  fifo;
    logic [2:0]  mode;
    logic [4:0]  irq_stat;
    logic [4:0]  irq_mask;
    tx_state_t   tx;
    logic [31:0] rdata;
    logic        ack;
    logic        req_o;
    logic        abort_o;
    logic [1:0]  pri_o;
    logic [1:0]  msel_o;
    logic [4:0]  fsel_o;
    logic        store_o;
    logic        irq_o;
  } state_t;

  state_t st_reg;
  state_t st_next;

  function automatic logic [7:0] filter_slot(input logic [31:0] w, input logic hi);
    filter_slot = hi ? w[FLT_HI_BASE +: 8] : w[FLT_LO_BASE +: 8];
  endfunction

  function automatic logic [7:0] merge_slot(input logic [7:0] old, input logic [7:0] wr,
                                            input logic en);
    merge_slot = old[FLT_EN_POS] ? {en, old[6:0]} : wr;
  endfunction

  logic        wr_acc;
  logic        rd_acc;
  logic        cfg_mode;
  logic [7:0]  slot;
  logic [7:0]  f31;
  logic [7:0]  f30;
  logic [4:0]  ev;

  always_comb begin
    st_next  = st_reg;
    wr_acc   = wb_cyc_in && wb_stb_in && !st_reg.ack && wb_we_in;
    rd_acc   = wb_cyc_in && wb_stb_in && !st_reg.ack && !wb_we_in;
    cfg_mode = (st_reg.mode == MODE_CONFIG);
    slot     = filter_slot(st_reg.flt, rx_filter_in[0]);
    f31      = st_reg.flt[FLT_HI_BASE +: 8];
    f30      = st_reg.flt[FLT_LO_BASE +: 8];
    ev       = '0;
    st_next.ack     = wb_cyc_in && wb_stb_in && !st_reg.ack;
    st_next.store_o = 1'b0;
    st_next.abort_o = 1'b0;

    // --------------------------------------------------------------------
    // Register writes
    // --------------------------------------------------------------------
    if (wr_acc && wb_adr_in == OFF_FILTER_CTRL) begin
      // An enabled filter keeps its fields; only its enable bit may drop.
      if (wb_sel_in[3]) begin
        st_next.flt[31:24] = merge_slot(f31, wb_dat_in[31:24], wb_dat_in[31]);
      end
      if (wb_sel_in[2]) begin
        st_next.flt[23:16] = merge_slot(f30, wb_dat_in[23:16], wb_dat_in[23]);
      end
    end
    if (wr_acc && wb_adr_in == OFF_MAIN_CTRL && wb_sel_in[2]) begin
      st_next.mode = wb_dat_in[MODE_LSB +: 3];
    end
    if (wr_acc && wb_adr_in == OFF_IRQ_MASK && wb_sel_in[0]) begin
      st_next.irq_mask = wb_dat_in[4:0];
    end
    if (wr_acc && wb_adr_in == OFF_FIFO_CTRL && wb_sel_in[0]) begin
      if (cfg_mode) begin
        st_next.fifo[FIFO_DIR_POS]              = wb_dat_in[FIFO_DIR_POS];
        st_next.fifo[FIFO_RTR_POS]              = wb_dat_in[FIFO_RTR_POS];
        st_next.fifo[FIFO_PRI_LSB +: 2]         = wb_dat_in[1:0];
      end
      if (st_reg.fifo[FIFO_DIR_POS]) begin
        if (wb_dat_in[FIFO_REQ_POS] && st_reg.tx == TX_IDLE) begin
          st_next.fifo[FIFO_REQ_POS] = 1'b1;
          st_next.tx                 = TX_BUSY;
        end else if (!wb_dat_in[FIFO_REQ_POS] && st_reg.fifo[FIFO_REQ_POS]) begin
          st_next.tx      = TX_ABRT;
          st_next.abort_o = 1'b1;
        end
      end
    end

    // --------------------------------------------------------------------
    // Read side effects
    // --------------------------------------------------------------------
    if (rd_acc && wb_adr_in == OFF_FIFO_CTRL) begin
      st_next.fifo[FIFO_LARB_POS] = 1'b0;
      st_next.fifo[FIFO_BERR_POS] = 1'b0;
    end

    // --------------------------------------------------------------------
    // Transmit engine events; sets win over the read clear
    // --------------------------------------------------------------------
    if (tx_lost_arb_in && st_reg.tx != TX_IDLE) begin
      st_next.fifo[FIFO_LARB_POS] = 1'b1;
      ev[IRQ_LARB_POS] = 1'b1;
    end
    if (tx_bus_err_in && st_reg.tx != TX_IDLE) begin
      st_next.fifo[FIFO_BERR_POS] = 1'b1;
      ev[IRQ_BERR_POS] = 1'b1;
    end
    if (tx_aborted_in && st_reg.tx != TX_IDLE) begin
      st_next.fifo[FIFO_ABORT_POS] = 1'b1;
      st_next.fifo[FIFO_REQ_POS]   = 1'b0;
      st_next.tx                   = TX_IDLE;
      ev[IRQ_ABORT_POS] = 1'b1;
    end else if (tx_done_in && st_reg.tx != TX_IDLE) begin
      // A send that ends after an abort was asked still ends, so the abort state cannot hang.
      st_next.fifo[FIFO_ABORT_POS] = 1'b0;
      if (tx_queue_empty_in) begin
        st_next.fifo[FIFO_REQ_POS] = 1'b0;
        st_next.tx                 = TX_IDLE;
        ev[IRQ_DONE_POS] = 1'b1;
      end
    end
    if (rx_valid_in && rx_remote_in && st_reg.fifo[FIFO_RTR_POS]
        && st_reg.fifo[FIFO_DIR_POS] && st_reg.tx == TX_IDLE) begin
      st_next.fifo[FIFO_REQ_POS] = 1'b1;
      st_next.tx                 = TX_BUSY;
    end

    // --------------------------------------------------------------------
    // Acceptance filtering
    // --------------------------------------------------------------------
    if (rx_valid_in && rx_id_hit_in && slot[FLT_EN_POS]) begin
      st_next.store_o  = 1'b1;
      st_next.msel_o   = slot[FLT_MSEL_LSB +: 2];
      st_next.fsel_o   = slot[FLT_FSEL_LSB +: 5];
      ev[IRQ_MATCH_POS] = 1'b1;
    end

    // FIFO reset clears every status flag and drops any pending send.
    if (fifo_reset_in) begin
      st_next.fifo[FIFO_ABORT_POS] = 1'b0;
      st_next.fifo[FIFO_LARB_POS]  = 1'b0;
      st_next.fifo[FIFO_BERR_POS]  = 1'b0;
      st_next.fifo[FIFO_REQ_POS]   = 1'b0;
      st_next.tx                   = TX_IDLE;
    end

    // --------------------------------------------------------------------
    // Interrupt status, read to clear; new events win over the clear
    // --------------------------------------------------------------------
    if (rd_acc && wb_adr_in == OFF_IRQ_STATUS) begin
      st_next.irq_stat = ev;
    end else begin
      st_next.irq_stat = st_reg.irq_stat | ev;
    end

    // --------------------------------------------------------------------
    // Read data
    // --------------------------------------------------------------------
    st_next.rdata = RESET_WORD;
    if (rd_acc) begin
      unique case (wb_adr_in)
        OFF_FILTER_CTRL: st_next.rdata = {st_reg.flt[31:16], 16'h0000};
        OFF_FIFO_CTRL:   st_next.rdata = {24'h00_0000, st_reg.fifo};
        OFF_MAIN_CTRL:   st_next.rdata = {8'h00, st_reg.mode, 21'h00_0000};
        OFF_IRQ_STATUS:  st_next.rdata = {27'h000_0000, st_reg.irq_stat};
        OFF_IRQ_MASK:    st_next.rdata = {27'h000_0000, st_reg.irq_mask};
        OFF_MATCH_STAT:  st_next.rdata = {23'h00_0000, st_reg.msel_o, st_reg.fsel_o,
                                          st_reg.tx};
        default:         st_next.rdata = RESET_WORD;
      endcase
    end

    st_next.req_o = st_next.fifo[FIFO_REQ_POS];
    st_next.pri_o = st_next.fifo[FIFO_PRI_LSB +: 2];
    st_next.irq_o = |(st_next.irq_stat & st_next.irq_mask);
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      st_reg      <= '0;
      st_reg.mode <= MODE_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  assign wb_dat_out      = st_reg.rdata;
  assign wb_ack_out      = st_reg.ack;
  assign tx_request_out  = st_reg.req_o;
  assign tx_abort_out    = st_reg.abort_o;
  assign tx_priority_out = st_reg.pri_o;
  assign mask_sel_out    = st_reg.msel_o;
  assign store_fifo_out  = st_reg.fsel_o;
  assign store_valid_out = st_reg.store_o;
  assign irq_out         = st_reg.irq_o;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  a_filter_gate: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    rx_valid_in && rx_id_hit_in && !slot[FLT_EN_POS]
      |=> !store_valid_out)
    else $error("Disabled filter stored a message.");
  a_mask_pick: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    rx_valid_in && rx_id_hit_in && slot[FLT_EN_POS] |=> mask_sel_out == $past(slot[6:5]))
    else $error("Wrong mask selected.");
  a_fifo_pick: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    rx_valid_in && rx_id_hit_in && slot[FLT_EN_POS] |=> store_fifo_out == $past(slot[4:0]))
    else $error("Wrong FIFO selected.");
  a_flt_lock: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    st_reg.flt[31] && st_reg.flt[31] == st_next.flt[31]
      |=> st_reg.flt[30:24] == $past(st_reg.flt[30:24]))
    else $error("Enabled filter fields changed.");
  a_larb_set: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    tx_lost_arb_in && st_reg.tx != TX_IDLE && !fifo_reset_in |=> st_reg.fifo[5])
    else $error("Lost arbitration not flagged.");
  a_berr_set: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    tx_bus_err_in && st_reg.tx != TX_IDLE && !fifo_reset_in |=> st_reg.fifo[4])
    else $error("Bus error not flagged.");
  a_read_clear: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    rd_acc && wb_adr_in == OFF_FIFO_CTRL && !tx_lost_arb_in && !tx_bus_err_in
      |=> !st_reg.fifo[5] && !st_reg.fifo[4])
    else $error("Read did not clear error flags.");
  a_rx_noreq: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    !st_reg.fifo[7] && !st_reg.fifo[3] |=> !st_reg.fifo[3])
    else $error("Receive FIFO raised send request.");
  a_abort_stable: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    !tx_aborted_in && !tx_done_in && !fifo_reset_in |=> $stable(st_reg.fifo[6]))
    else $error("Aborted flag changed without cause.");
  a_cfg_lock: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    st_reg.mode != MODE_CONFIG |=> $stable(st_reg.fifo[1:0]))
    else $error("Priority changed outside configuration mode.");
  a_cfg_dir_lock: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    st_reg.mode != MODE_CONFIG |=> $stable(st_reg.fifo[7]) && $stable(st_reg.fifo[2]))
    else $error("Direction or auto reply changed outside configuration mode.");
  a_flt31_write: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    wr_acc && wb_adr_in == OFF_FILTER_CTRL && wb_sel_in[3] && !st_reg.flt[31]
      |=> st_reg.flt[31:24] == $past(wb_dat_in[31:24]))
    else $error("Disabled filter 31 refused a write.");
  a_flt30_write: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    wr_acc && wb_adr_in == OFF_FILTER_CTRL && wb_sel_in[2] && !st_reg.flt[23]
      |=> st_reg.flt[23:16] == $past(wb_dat_in[23:16]))
    else $error("Disabled filter 30 refused a write.");
  a_flt30_lock: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    st_reg.flt[23] && st_reg.flt[23] == st_next.flt[23]
      |=> st_reg.flt[22:16] == $past(st_reg.flt[22:16]))
    else $error("Enabled filter 30 fields changed.");

  // ----------------------------------------------------------------------
  // Checks on the transmit control
  // ----------------------------------------------------------------------
  a_abort_set: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    tx_aborted_in && st_reg.tx != TX_IDLE && !fifo_reset_in |=> st_reg.fifo[6])
    else $error("Abort not flagged.");
  a_done_clear: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    tx_done_in && !tx_aborted_in && st_reg.tx != TX_IDLE && !fifo_reset_in
      |=> !st_reg.fifo[6])
    else $error("Aborted flag kept after a good send.");
  a_req_done: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    tx_done_in && !tx_aborted_in && tx_queue_empty_in && st_reg.tx != TX_IDLE
      |=> !tx_request_out)
    else $error("Send request kept after the last message.");
  a_req_write: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    wr_acc && wb_adr_in == OFF_FIFO_CTRL && wb_sel_in[0] && wb_dat_in[3] && st_reg.fifo[7]
      && st_reg.tx == TX_IDLE && !fifo_reset_in |=> tx_request_out)
    else $error("Send request not taken.");
  a_abort_pulse: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    wr_acc && wb_adr_in == OFF_FIFO_CTRL && wb_sel_in[0] && !wb_dat_in[3] && st_reg.fifo[7]
      && st_reg.fifo[3] |=> tx_abort_out)
    else $error("Cleared request did not ask for an abort.");
  a_remote_reply: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    rx_valid_in && rx_remote_in && st_reg.fifo[2] && st_reg.fifo[7] && st_reg.tx == TX_IDLE
      && !fifo_reset_in |=> tx_request_out)
    else $error("Remote request not answered.");
  a_remote_ignored: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    rx_valid_in && rx_remote_in && !st_reg.fifo[2] && !st_reg.fifo[3]
      && !(wr_acc && wb_adr_in == OFF_FIFO_CTRL) |=> !tx_request_out)
    else $error("Remote request raised a send with auto reply off.");
  a_pri_write: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    wr_acc && wb_adr_in == OFF_FIFO_CTRL && wb_sel_in[0] && cfg_mode
      |=> tx_priority_out == $past(wb_dat_in[1:0]))
    else $error("Priority write not applied.");
  a_fifo_reset: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    fifo_reset_in |=> !st_reg.fifo[6] && !st_reg.fifo[5] && !st_reg.fifo[4] && !tx_request_out)
    else $error("FIFO reset left a flag set.");

  // ----------------------------------------------------------------------
  // Checks on the register bus and interrupt
  // ----------------------------------------------------------------------
  a_ack_pulse: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    wb_ack_out |=> !wb_ack_out)
    else $error("Acknowledge stood longer than one cycle.");
  a_irq_sticky: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    st_reg.irq_stat[IRQ_DONE_POS] && !(rd_acc && wb_adr_in == OFF_IRQ_STATUS)
      |=> st_reg.irq_stat[IRQ_DONE_POS])
    else $error("Done status dropped without a read.");
endmodule

// *** verif/can_engine_model.sv ***
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Protocol engine model
// ----------------------------------------------------------------------
module can_engine_model (
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_b_in,
  // From the block
  input  wire logic       tx_request_in,
  input  wire logic       tx_abort_in,
  // Bench control
  input  wire logic       slow_in,
  input  wire logic       multi_in,
  input  wire logic [1:0] fault_in,
  // To the block
  output logic            tx_done_out,
  output logic            tx_aborted_out,
  output logic            tx_lost_arb_out,
  output logic            tx_bus_err_out,
  output logic            tx_queue_empty_out
);
  logic [5:0] cnt_reg;
  logic       busy_reg;
  logic       more_reg;
  // With multi set a second message follows, so the first completion is not the last.
  // Busy holds until the request falls, so one request is sent only once.
  always_ff @(posedge clk_in) begin
    tx_done_out     <= 1'b0;
    tx_aborted_out  <= 1'b0;
    tx_lost_arb_out <= 1'b0;
    tx_bus_err_out  <= 1'b0;
    if (!rst_b_in) begin
      cnt_reg            <= 6'h00;
      busy_reg           <= 1'b0;
      more_reg           <= 1'b0;
      tx_queue_empty_out <= 1'b1;
    end else if (tx_abort_in && cnt_reg != 6'h00) begin
      cnt_reg        <= 6'h00;
      more_reg       <= 1'b0;
      tx_aborted_out <= 1'b1;
    end else if (tx_request_in && !busy_reg) begin
      busy_reg <= 1'b1;
      more_reg <= multi_in;
      cnt_reg  <= slow_in ? 6'h28 : 6'h03;
    end else if (cnt_reg == 6'h02) begin
      tx_lost_arb_out <= fault_in[0];
      tx_bus_err_out  <= fault_in[1];
      cnt_reg         <= 6'h01;
    end else if (cnt_reg == 6'h01) begin
      tx_done_out        <= 1'b1;
      tx_queue_empty_out <= !more_reg;
      more_reg           <= 1'b0;
      cnt_reg            <= more_reg ? 6'h03 : 6'h00;
    end else if (cnt_reg != 6'h00) begin
      cnt_reg <= cnt_reg - 6'h01;
    end else if (!tx_request_in) begin
      busy_reg <= 1'b0;
    end
  end
endmodule

// *** verif/can_filter_fifo_tx_control_bench.sv ***
`timescale 1ns/1ps
module can_filter_fifo_tx_control_bench;
  import can_ctl_pkg::*;
  logic        clk_in, rst_b_in, wb_cyc, wb_stb, wb_we, wb_ack, rx_valid, rx_remote;
  logic        rx_hit, done, aborted, larb, berr, qempty, fifo_rst, slow;
  logic        req, abort, store_valid, irq, multi;
  logic        held = 1'b0;
  logic [1:0]  rx_filter, fault, prio, msel;
  logic [4:0]  store_fifo;
  logic [7:0]  wb_adr;
  logic [3:0]  wb_sel, lanes;
  logic [31:0] wb_wdat, wb_rdat, q, r, d;
  logic [31:0] seed = 32'h0000_F346;
  int          fail_count = 0, n_tests = 0, n_abort = 0, cycles = 0;
  // ----------------------------------------------------------------------
  // Design and engine
  // ----------------------------------------------------------------------
  can_filter_fifo_tx_control i_dut (.clk_in(clk_in), .rst_b_in(rst_b_in), .wb_cyc_in(wb_cyc),
    .wb_stb_in(wb_stb), .wb_we_in(wb_we), .wb_adr_in(wb_adr), .wb_sel_in(wb_sel),
    .wb_dat_in(wb_wdat), .wb_dat_out(wb_rdat), .wb_ack_out(wb_ack), .rx_valid_in(rx_valid),
    .rx_filter_in(rx_filter), .rx_remote_in(rx_remote), .rx_id_hit_in(rx_hit),
    .tx_done_in(done), .tx_aborted_in(aborted), .tx_lost_arb_in(larb), .tx_bus_err_in(berr),
    .tx_queue_empty_in(qempty), .fifo_reset_in(fifo_rst), .tx_request_out(req),
    .tx_abort_out(abort), .tx_priority_out(prio), .mask_sel_out(msel),
    .store_fifo_out(store_fifo), .store_valid_out(store_valid), .irq_out(irq));
  can_engine_model i_engine (.clk_in(clk_in), .rst_b_in(rst_b_in), .tx_request_in(req),
    .tx_abort_in(abort), .slow_in(slow), .multi_in(multi), .fault_in(fault),
    .tx_done_out(done), .tx_aborted_out(aborted), .tx_lost_arb_out(larb),
    .tx_bus_err_out(berr),
    .tx_queue_empty_out(qempty));
  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [3:0] flags_exp(input int k);
    return {1'b0, k == 1, k == 2, 1'b0};
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // A cycle waits for ack with no assumed latency; the watchdog ends a hang.
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] dat);
    @(posedge clk_in);
    wb_cyc  <= 1'b1;
    wb_stb  <= 1'b1;
    wb_we   <= we;
    wb_adr  <= a;
    wb_sel  <= lanes;
    wb_wdat <= dat;
    do @(posedge clk_in); while (wb_ack !== 1'b1);
    q = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask
  task automatic rx(input logic f, input logic rem);
    @(posedge clk_in);
    rx_valid  <= 1'b1;
    rx_filter <= {seed[7], f};
    rx_remote <= rem;
    @(posedge clk_in);
    rx_valid <= 1'b0;
    #1;
  endtask
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // ----------------------------------------------------------------------
  // Clock, watchdog and pulse counter
  // ----------------------------------------------------------------------
  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    cycles++;
    if (abort === 1'b1) n_abort++;
    if (held) chk("request held", req, 1'b1);
    held = (done === 1'b1 && qempty === 1'b0);
    if (cycles == 20000) begin
      fail_count++;
      stop_test();
    end
  end
  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  initial begin
    {rst_b_in, wb_cyc, wb_stb, wb_we, rx_valid, rx_remote, fifo_rst, slow, multi} = '0;
    lanes = 4'hF;
    {wb_adr, wb_wdat, rx_filter, fault} = '0;
    rx_hit = 1'b1;
    wb_sel = 4'hF;
    repeat (12) @(posedge clk_in);
    rst_b_in <= 1'b1;
    wb(0, OFF_FILTER_CTRL, 0);
    chk("filter reset", q, RESET_WORD);
    wb(0, OFF_FIFO_CTRL, 0);
    chk("fifo reset", q, RESET_WORD);
    wb(0, OFF_MAIN_CTRL, 0);
    chk("mode reset", q[23:21], MODE_CONFIG);
    wb(0, 8'h20, rnd());
    chk("unmapped", q, 32'h0000_0000);
    for (int i = 0; i < 4; i++) begin
      r = rnd();
      d = {1'b1, i[1:0], r[4:0], 1'b0, r[14:8], 16'h0000};
      wb(1, OFF_FILTER_CTRL, d & 32'h7FFF_FFFF);
      wb(1, OFF_FILTER_CTRL, d);
      wb(1, OFF_FILTER_CTRL, d ^ 32'h7F00_0000);
      wb(0, OFF_FILTER_CTRL, 0);
      chk("filter word", q, d);
      rx(1'b1, 1'b0);
      chk("store valid", store_valid, 1);
      chk("mask select", msel, i);
      chk("store fifo", store_fifo, r[4:0]);
      rx(1'b0, 1'b0);
      chk("disabled filter", store_valid, 0);
    end
    wb(0, OFF_MATCH_STAT, 0);
    chk("match status", q, {23'h00_0000, 2'b11, r[4:0], TX_IDLE});
    lanes = 4'h4;
    wb(1, OFF_FILTER_CTRL, 0);
    lanes = 4'hF;
    wb(0, OFF_FILTER_CTRL, 0);
    chk("lane write", q, {d[31:24], 24'h00_0000});
    r = rnd();
    wb(1, OFF_FIFO_CTRL, {24'h00_0000, 6'h20, r[1:0]});
    chk("priority out", prio, r[1:0]);
    wb(1, OFF_MAIN_CTRL, 32'h0000_0000);
    wb(1, OFF_FIFO_CTRL, {24'h00_0000, 6'h20, ~r[1:0]});
    chk("priority locked", prio, r[1:0]);
    wb(0, OFF_IRQ_STATUS, 0);
    wb(1, OFF_IRQ_MASK, 32'h0000_0001 << IRQ_DONE_POS);
    for (int k = 0; k < 3; k++) begin
      fault <= k[1:0];
      multi <= (k == 2);
      wb(1, OFF_FIFO_CTRL, 32'h0000_0088);
      while (req !== 1'b0) @(posedge clk_in);
      wb(0, OFF_FIFO_CTRL, 0);
      chk("tx flags", q[6:3], flags_exp(k));
      wb(0, OFF_FIFO_CTRL, 0);
      chk("flags after read", q[5:4], 0);
    end
    chk("irq raised", irq, 1);
    wb(0, OFF_IRQ_STATUS, 0);
    chk("done status", q[IRQ_DONE_POS], 1);
    @(posedge clk_in);
    #1;
    chk("irq cleared", irq, 0);
    slow <= 1'b1;
    multi <= 1'b0;
    wb(1, OFF_FIFO_CTRL, 32'h0000_0008);
    repeat (4) @(posedge clk_in);
    wb(1, OFF_FIFO_CTRL, 32'h0000_0000);
    repeat (6) @(posedge clk_in);
    chk("abort pulses", n_abort, 1);
    wb(0, OFF_FIFO_CTRL, 0);
    wb(0, OFF_FIFO_CTRL, 0);
    chk("aborted flag", q[6], 1);
    fifo_rst <= 1'b1;
    @(posedge clk_in);
    fifo_rst <= 1'b0;
    wb(0, OFF_FIFO_CTRL, 0);
    chk("fifo reset flag", q[6:4], 0);
    slow <= 1'b0;
    wb(1, OFF_MAIN_CTRL, {8'h00, MODE_CONFIG, 21'h00_0000});
    wb(1, OFF_FIFO_CTRL, 32'h0000_0000);
    wb(1, OFF_FIFO_CTRL, 32'h0000_0008);
    chk("receive fifo", req, 0);
    wb(1, OFF_FIFO_CTRL, 32'h0000_0080);
    rx(1'b1, 1'b1);
    chk("remote ignored", req, 0);
    wb(1, OFF_IRQ_MASK, 32'h0000_0000);
    wb(1, OFF_FIFO_CTRL, 32'h0000_0084);
    rx(1'b1, 1'b1);
    chk("remote reply", req, 1);
    while (req !== 1'b0) @(posedge clk_in);
    repeat (2) @(posedge clk_in);
    chk("irq masked", irq, 0);
    wb(0, OFF_IRQ_STATUS, 0);
    chk("masked status", q[IRQ_DONE_POS], 1);
    stop_test();
  end
endmodule
